/* logic/ass_pkg.sv */
// package: constants and types for the sweep sequencer
package ass_pkg;
  localparam int unsigned CLK_HZ        = 200000000;
  localparam int unsigned ADW           = 10;
  localparam int unsigned NCH           = 8;
  localparam int unsigned CHW           = 3;
  localparam logic [9:0]  SAR_INIT      = 10'h200;
  localparam int unsigned SAR_TOP_BIT   = 9;
  localparam int unsigned STEP_CYCLES   = 4;
  localparam logic [3:0]  STEP_CNT_MAX  = 4'(STEP_CYCLES - 1);
  localparam int unsigned REF_MIN_US    = 1;
  localparam int unsigned REF_WAIT_CYC  = (CLK_HZ / 1000000) * REF_MIN_US;
  localparam logic [1:0]  MODE_SINGLE   = 2'h0;
  localparam logic [1:0]  MODE_REP0     = 2'h1;
  localparam logic [1:0]  MODE_REP1     = 2'h2;
  localparam logic [1:0]  DIV_BY4       = 2'h0;
  localparam logic [1:0]  DIV_BY2       = 2'h1;
  localparam logic [1:0]  DIV_NONE      = 2'h2;
  localparam logic [1:0]  DIV_MAX4      = 2'h3;
  localparam logic [1:0]  DIV_MAX2      = 2'h1;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] group;
    logic [1:0] clk_div;
    logic       res_8bit;
  } ass_cfg_t;

  typedef struct packed {
    logic           valid;
    logic [CHW-1:0] chan;
    logic [ADW-1:0] value;
  } ass_result_t;
endpackage

/* logic/ass_clk_div.sv */
// conversion clock enable generator: divide by 4, by 2, or undivided
`timescale 1ns/1ps
`default_nettype none
module ass_clk_div
  import ass_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] clk_div,
  output logic            tick
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic [1:0] lim;
  logic       next_tick;

  always_comb
  begin
    case (clk_div)
      DIV_BY4: lim = DIV_MAX4;
      DIV_BY2: lim = DIV_MAX2;
      default: lim = 2'h0;
    endcase
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run)
    begin
      next_cnt = 2'h0;
    end
    else if (cnt >= lim)
    begin
      next_cnt  = 2'h0;
      next_tick = 1'b1;
    end
    else
    begin
      next_cnt = cnt + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt  <= 2'h0;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* logic/ass_sar.sv */
// successive approximation engine: one 10-bit conversion per start pulse
`timescale 1ns/1ps
`default_nettype none
module ass_sar
  import ass_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           tick,
  input  wire logic           start,
  input  wire logic           abort,
  input  wire logic           cmp_in,
  output logic [ADW-1:0]      trial,
  output logic                busy,
  output logic                done
);
  typedef enum logic [1:0] {SAR_IDLE, SAR_STEP} ass_sar_st_t;
  ass_sar_st_t     st;
  ass_sar_st_t     next_st;
  logic [ADW-1:0]  next_trial;
  logic [3:0]      bitn;
  logic [3:0]      next_bitn;
  logic [3:0]      cyc;
  logic [3:0]      next_cyc;
  logic            next_done;

  always_comb
  begin
    next_st    = st;
    next_trial = trial;
    next_bitn  = bitn;
    next_cyc   = cyc;
    next_done  = 1'b0;
    case (st)
      SAR_IDLE:
      begin
        if (start)
        begin
          next_trial = SAR_INIT;
          next_bitn  = 4'(SAR_TOP_BIT);
          next_cyc   = 4'h0;
          next_st    = SAR_STEP;
        end
      end
      SAR_STEP:
      begin
        if (abort)
        begin
          next_st = SAR_IDLE;
        end
        else if (tick)
        begin
          if (cyc != STEP_CNT_MAX)
          begin
            next_cyc = cyc + 4'h1;
          end
          else
          begin
            // comparator bit sampled at the step end: 1 means ladder below input
            next_cyc = 4'h0;
            if (!cmp_in)
            begin
              next_trial[bitn] = 1'b0;
            end
            if (bitn == 4'h0)
            begin
              next_st   = SAR_IDLE;
              next_done = 1'b1;
            end
            else
            begin
              next_bitn              = bitn - 4'h1;
              next_trial[bitn - 4'h1] = 1'b1;
            end
          end
        end
      end
      default: next_st = SAR_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st    <= SAR_IDLE;
      trial <= 10'h000;
      bitn  <= 4'h0;
      cyc   <= 4'h0;
      done  <= 1'b0;
    end
    else
    begin
      st    <= next_st;
      trial <= next_trial;
      bitn  <= next_bitn;
      cyc   <= next_cyc;
      done  <= next_done;
    end
  end

  assign busy = (st != SAR_IDLE);
endmodule
`default_nettype wire

/* logic/ass_sweep_top.sv */
// sweep sequencer top: channel order, result registers, completion request
`timescale 1ns/1ps
`default_nettype none
module ass_sweep_top
  import ass_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ass_pkg::ass_cfg_t     cfg,
  input  wire logic                  start_set,
  input  wire logic                  start_clr,
  input  wire logic                  irq_clr,
  input  wire logic                  cmp_in,
  output logic                       start_flag,
  output logic                       irq_req,
  output logic [ass_pkg::CHW-1:0]    analog_channel_n,
  output logic [ass_pkg::ADW-1:0]    ladder_code,
  output logic                       ladder_zero,
  output ass_pkg::ass_result_t       result,
  output logic [ass_pkg::NCH*ass_pkg::ADW-1:0] result_regs
);
  import ass_pkg::*;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_KICK, SEQ_CONV} ass_seq_st_t;
  ass_seq_st_t st;
  ass_seq_st_t next_st;

  logic               cmp_s1;
  logic               cmp_s2;
  logic               tick;
  logic               sar_start;
  logic               sar_busy;
  logic               sar_done;
  logic [ADW-1:0]     trial;
  logic               next_start_flag;
  logic               next_irq_req;
  logic [CHW-1:0]     next_chan;
  logic [CHW-1:0]     last_sel;
  logic [CHW-1:0]     extra;
  logic [CHW-1:0]     next_extra;
  logic               in_extra;
  logic               next_in_extra;
  logic [ADW-1:0]     res_val;
  ass_result_t        next_result;
  logic [ADW-1:0]     regs [NCH];
  logic [ADW-1:0]     next_regs [NCH];
  logic [ADW-1:0]     next_ladder_code;
  logic               next_ladder_zero;

  // comparator is an asynchronous analog output
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end
    else
    begin
      cmp_s1 <= cmp_in;
      cmp_s2 <= cmp_s1;
    end
  end

  ass_clk_div u_div (
    .clk     (clk),
    .rst     (rst),
    .run     (start_flag),
    .clk_div (cfg.clk_div),
    .tick    (tick)
  );

  ass_sar u_sar (
    .clk    (clk),
    .rst    (rst),
    .tick   (tick),
    .start  (sar_start),
    .abort  (!start_flag),
    .cmp_in (cmp_s2),
    .trial  (trial),
    .busy   (sar_busy),
    .done   (sar_done)
  );

  always_comb
  begin
    if (cfg.mode == MODE_REP1)
    begin
      last_sel = {1'b0, cfg.group};
    end
    else
    begin
      last_sel = {cfg.group, 1'b1};
    end
  end

  // 8-bit mode keeps the upper eight bits shifted down; the top two bits read as zero
  assign res_val   = cfg.res_8bit ? {2'h0, trial[ADW-1:2]} : trial;
  assign sar_start = (st == SEQ_KICK);

  always_comb
  begin
    next_st         = st;
    next_start_flag = start_flag;
    next_irq_req    = irq_req;
    next_chan       = analog_channel_n;
    next_extra      = extra;
    next_in_extra   = in_extra;
    next_result     = result;
    next_result.valid = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      next_regs[i] = regs[i];
    end
    if (irq_clr)
    begin
      next_irq_req = 1'b0;
    end
    if (start_set)
    begin
      next_start_flag = 1'b1;
    end
    if (start_clr)
    begin
      next_start_flag = 1'b0;
    end
    case (st)
      SEQ_IDLE:
      begin
        if (start_flag)
        begin
          next_chan     = 3'h0;
          next_in_extra = 1'b0;
          next_extra    = last_sel + 3'h1;
          next_st       = SEQ_KICK;
        end
      end
      SEQ_KICK:
      begin
        next_st = SEQ_CONV;
      end
      SEQ_CONV:
      begin
        if (!start_flag)
        begin
          next_st = SEQ_IDLE;
        end
        else if (sar_done)
        begin
          next_regs[analog_channel_n] = res_val;
          next_result.valid = 1'b1;
          next_result.chan  = analog_channel_n;
          next_result.value = res_val;
          next_st           = SEQ_KICK;
          if (cfg.mode == MODE_REP1)
          begin
            if (in_extra)
            begin
              next_chan     = 3'h0;
              next_in_extra = 1'b0;
              next_extra    = (extra == 3'h7) ? last_sel + 3'h1 : extra + 3'h1;
            end
            else if (analog_channel_n == last_sel)
            begin
              next_chan     = extra;
              next_in_extra = 1'b1;
            end
            else
            begin
              next_chan = analog_channel_n + 3'h1;
            end
          end
          else if (analog_channel_n != last_sel)
          begin
            next_chan = analog_channel_n + 3'h1;
          end
          else if (cfg.mode == MODE_REP0)
          begin
            next_chan = 3'h0;
          end
          else
          begin
            // completion set wins over a same-cycle clear
            next_irq_req    = 1'b1;
            next_start_flag = 1'b0;
            next_st         = SEQ_IDLE;
          end
        end
      end
      default: next_st = SEQ_IDLE;
    endcase
    next_ladder_code = sar_busy ? trial : 10'h000;
    next_ladder_zero = (next_ladder_code == 10'h000);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st               <= SEQ_IDLE;
      start_flag       <= 1'b0;
      irq_req          <= 1'b0;
      analog_channel_n <= 3'h0;
      extra            <= 3'h0;
      in_extra         <= 1'b0;
      result           <= '0;
      ladder_code      <= 10'h000;
      ladder_zero      <= 1'b1;
      for (int i = 0; i < NCH; i++)
      begin
        regs[i] <= 10'h000;
      end
    end
    else
    begin
      st               <= next_st;
      start_flag       <= next_start_flag;
      irq_req          <= next_irq_req;
      analog_channel_n <= next_chan;
      extra            <= next_extra;
      in_extra         <= next_in_extra;
      result           <= next_result;
      ladder_code      <= next_ladder_code;
      ladder_zero      <= next_ladder_zero;
      for (int i = 0; i < NCH; i++)
      begin
        regs[i] <= next_regs[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_out
      assign result_regs[g*ADW +: ADW] = regs[g];
    end
  endgenerate
endmodule
`default_nettype wire

/* verification/ass_analog_model.sv */
// model of the analog side: input mux, ladder and comparator
`timescale 1ns/1ps
`default_nettype none
module ass_analog_model
(
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [2:0]  chan,
  input  wire logic [9:0]  code,
  input  wire logic [79:0] levels,
  output logic             cmp
);
  logic now_cmp;
  logic lag;
  // ladder for code n sits half a step below n, so it is under level k exactly when n <= k
  assign now_cmp = code <= levels[chan*10 +: 10];
  // a full-cycle lag would miss the last sample of an undivided 4-cycle step
  always_ff @(negedge clk)
    lag <= now_cmp;
  // slow answer lags half a cycle, still settled before the step ends
  assign cmp = slow ? lag : now_cmp;
endmodule
`default_nettype wire

/* verification/ass_sweep_asserts.sv */
// checker: channel order, completion and result properties of the sweep top
`timescale 1ns/1ps
`default_nettype none
module ass_sweep_asserts
  import ass_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire ass_pkg::ass_cfg_t    cfg,
  input  wire logic                 start_clr,
  input  wire logic                 start_flag,
  input  wire logic                 irq_req,
  input  wire logic                 ladder_zero,
  input  wire logic [ADW-1:0]       ladder_code,
  input  wire ass_pkg::ass_result_t result,
  input  wire logic [NCH*ADW-1:0]   result_regs
);
  logic           seen;
  logic [CHW-1:0] prev;
  logic [ADW-1:0] hv;
  function automatic logic nxt_ok(logic [2:0] p, logic [2:0] c, ass_cfg_t f);
    if (f.mode == MODE_REP1)
      return (p < {1'b0, f.group}) ? c == p + 3'h1 : (p == {1'b0, f.group}) ? c > {1'b0, f.group} : c == 3'h0;
    return c == ((p == {f.group, 1'b1}) ? 3'h0 : p + 3'h1);
  endfunction
  always_ff @(posedge clk)
    if (rst || (!start_flag && !result.valid))
      seen <= 1'b0;
    else if (result.valid)
      seen <= 1'b1;
  always_ff @(posedge clk)
    if (result.valid)
    begin
      prev <= result.chan;
      hv   <= result.value;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_chan_order: assert property (result.valid |-> (seen ? nxt_ok(prev, result.chan, cfg) : result.chan == 3'h0))
    else $error("channel out of order");
  a_regs_write: assert property ($past(result.valid) |-> result_regs[prev*10 +: 10] == hv)
    else $error("result register not written");
  a_irq_single: assert property ($rose(irq_req) |-> cfg.mode == MODE_SINGLE)
    else $error("request outside single sweep");
  a_sweep_end: assert property (result.valid && cfg.mode == MODE_SINGLE && result.chan == {cfg.group, 1'b1}
    |-> ##[0:2] (irq_req && !start_flag))
    else $error("single sweep did not finish");
  a_clr_stops: assert property (start_clr |=> !start_flag)
    else $error("start flag survived clear");
  a_rep_runs: assert property (start_flag && cfg.mode != MODE_SINGLE && !start_clr |=> start_flag)
    else $error("repeat sweep stopped by itself");
  a_sar_load: assert property ($fell(ladder_zero) |-> ladder_code == SAR_INIT)
    else $error("trial did not start at top bit");
  a_res_8bit: assert property (result.valid && cfg.res_8bit |-> result.value[9:8] == 2'h0)
    else $error("8-bit result too wide");
  c_irq: cover property ($rose(irq_req));
  c_rep1_other: cover property (result.valid && cfg.mode == MODE_REP1 && result.chan > {1'b0, cfg.group});
  c_abort: cover property (start_clr && !ladder_zero);
endmodule
bind ass_sweep_top ass_sweep_asserts chk (.clk(clk), .rst(rst), .cfg(cfg), .start_clr(start_clr),
  .start_flag(start_flag), .irq_req(irq_req), .ladder_zero(ladder_zero), .ladder_code(ladder_code),
  .result(result), .result_regs(result_regs));
`default_nettype wire

/* verification/ass_sweep_top_test.sv */
// testbench: random sweeps in every mode and group, each run with a randomly drawn divider
`timescale 1ns/1ps
`default_nettype none
module ass_sweep_top_test;
  import ass_pkg::*;
  `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, s); end end
  logic        clk = 0, rst = 1, start_set = 0, start_clr = 0, irq_clr = 0, slow = 0;
  logic        cmp_in, start_flag, irq_req, ladder_zero;
  ass_cfg_t    cfg = '0;
  logic [2:0]  chan;
  logic [9:0]  code;
  ass_result_t result;
  logic [79:0] regs, levels = '0;
  logic [31:0] seed = 32'h8ccd;
  int          n_fail = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  ass_sweep_top DUT (.clk(clk), .rst(rst), .cfg(cfg), .start_set(start_set), .start_clr(start_clr),
    .irq_clr(irq_clr), .cmp_in(cmp_in), .start_flag(start_flag), .irq_req(irq_req), .analog_channel_n(chan),
    .ladder_code(code), .ladder_zero(ladder_zero), .result(result), .result_regs(regs));
  ass_analog_model model (.clk(clk), .slow(slow), .chan(chan), .code(code), .levels(levels), .cmp(cmp_in));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] exp_chan(int k, logic [1:0] m, logic [1:0] g);
    int p;
    if (m != MODE_REP1)
      return 3'(k % (2 * g + 2));
    p = k % (g + 2);
    return (p <= g) ? 3'(p) : 3'(g + 1 + (k / (g + 2)) % (7 - g));
  endfunction
  function automatic logic [9:0] exp_val(logic [9:0] v, logic r8);
    return r8 ? {2'h0, v[9:2]} : v;
  endfunction
  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run(logic [1:0] m, logic [1:0] g, logic [1:0] d, logic r8, int n);
    int k;
    int t;
    k = 0;
    t = 0;
    // stopped here; mode and channel group are written together every run
    cfg <= '{m, g, d, r8};
    // no reference switch, key input, low supply or clock change is modelled here
    // analog lines are pure inputs of the model, driven only by the bench
    slow <= 1'(rnd());
    for (int i = 0; i < 8; i++)
      levels[i*10 +: 10] <= (i == 0) ? 10'h3ff : (i == 1) ? 10'h0 : 10'(rnd());
    @(posedge clk);
    start_set <= 1'b1;
    @(posedge clk);
    start_set <= 1'b0;
    while (k < n && t < 40000)
    begin
      @(posedge clk);
      t++;
      if (result.valid === 1'b1)
      begin
        `CHK("chan", exp_chan(k, m, g), result.chan)
        `CHK("value", exp_val(levels[result.chan*10 +: 10], r8), result.value)
        k++;
      end
    end
    while (m == MODE_SINGLE && irq_req !== 1'b1 && t < 40000)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 40000)
    begin
      n_fail++;
      tally_and_finish();
    end
    if (m == MODE_SINGLE)
    begin
      @(posedge clk);
      `CHK("flag", 1'b0, start_flag)
      // registers are read only once the request has been seen
      for (int i = 0; i <= 2 * g + 1; i++)
        `CHK("reg", exp_val(levels[i*10 +: 10], r8), regs[i*10 +: 10])
      irq_clr <= 1'b1;
      @(posedge clk);
      irq_clr <= 1'b0;
      @(posedge clk);
    end
    else
    begin
      `CHK("running", 1'b1, start_flag)
      start_clr <= 1'b1;
      @(posedge clk);
      start_clr <= 1'b0;
      k = 0;
      repeat (400)
      begin
        @(posedge clk);
        k += (result.valid === 1'b1);
      end
      `CHK("stray", 0, k)
    end
    `CHK("irq", 1'b0, irq_req)
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 3; m++)
      for (int g = 0; g < 4; g++)
        run(2'(m), 2'(g), 2'(rnd()), 1'(rnd()), m == 0 ? 2 * g + 2 : 20);
    tally_and_finish();
  end
endmodule
`default_nettype wire
